// file: rtl/uevc_map.svh
`ifndef UEVC_MAP_SVH
`define UEVC_MAP_SVH

// ----------------------------------------------------------------
// register indexes on the plain register port
// ----------------------------------------------------------------
`define UEVC_ADDR_W            6
`define UEVC_REG_ERR_FLAGS     6'h00
`define UEVC_REG_ERR_ENABLES   6'h01
`define UEVC_REG_PWM_CTRL      6'h02
`define UEVC_EP_SEL_HI         5
`define UEVC_EP_SEL_LO         4
`define UEVC_EP_SEL_VAL        2'h1

// ----------------------------------------------------------------
// error flag and enable fields
// ----------------------------------------------------------------
`define UEVC_ERR_BIT_STUFF     7
`define UEVC_ERR_OVERRUN       5
`define UEVC_ERR_TIMEOUT       4
`define UEVC_ERR_PARTIAL       3
`define UEVC_ERR_DATA_CRC      2
`define UEVC_ERR_TOKEN_FRAME   1
`define UEVC_ERR_PID           0
`define UEVC_ERR_IMPL_MASK     8'hbf
`define UEVC_ERR_RESET         8'h00

// ----------------------------------------------------------------
// endpoint control fields
// ----------------------------------------------------------------
`define UEVC_EP_LOW_SPEED      7
`define UEVC_EP_RETRY_DIS      6
`define UEVC_EP_SETUP_BLOCK    4
`define UEVC_EP_RX_EN          3
`define UEVC_EP_TX_EN          2
`define UEVC_EP_STALLED        1
`define UEVC_EP_HSHK_EN        0
`define UEVC_EP0_HOST_MASK     8'hdf
`define UEVC_EP_MASK           8'h1f
`define UEVC_EP_RESET          8'h00

// ----------------------------------------------------------------
// vbus generator control fields
// ----------------------------------------------------------------
`define UEVC_PWM_GEN_EN        15
`define UEVC_PWM_POL           9
`define UEVC_PWM_CNT_EN        8
`define UEVC_PWM_RESET         1'b0

`endif

// file: rtl/uevc_pkg.sv
`include "uevc_map.svh"

package uevc_pkg;

	// ------------------------------------------------------------
	// types
	// ------------------------------------------------------------
	typedef enum logic {
		ta_idle,
		ta_waiting
	} uevc_ta_state_t;

	// visible bits of one endpoint register
	function automatic logic [7:0] uevc_ep_view(input logic [3:0] idx,
	                                            input logic       host,
	                                            input logic [7:0] value);
		uevc_ep_view = (idx == 4'h0 && host) ?
		               (value & `UEVC_EP0_HOST_MASK) :
		               (value & `UEVC_EP_MASK);
	endfunction

endpackage

// file: rtl/uevc_err_flags.sv
`timescale 1ns/1ns
`include "uevc_map.svh"

module uevc_err_flags (
	input  wire logic       clock,
	input  wire logic       resetn,
	input  wire logic [7:0] event_vec,
	input  wire logic       clear_wr,
	input  wire logic [7:0] clear_data,
	input  wire logic       enable_wr,
	input  wire logic [7:0] enable_data,
	output logic      [7:0] flags,
	output logic      [7:0] enables,
	output logic            summary
);

	logic [7:0] next_flags;
	logic [7:0] next_enables;
	logic [7:0] clear_mask;

	// write-one-to-clear, a new event beats the clear
	always_comb begin
		clear_mask   = clear_wr ? clear_data : 8'h00;
		next_flags   = ((flags & ~clear_mask) | event_vec) &
		               `UEVC_ERR_IMPL_MASK; // [R9] [R24] [R22]
		next_enables = enable_wr ? (enable_data & `UEVC_ERR_IMPL_MASK) :
		               enables; // [R10] [R22]
	end

	// flag storage
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			flags <= `UEVC_ERR_RESET;
		end else begin
			flags <= next_flags; // [R1] [R5] [R8]
		end
	end

	// enable storage
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			enables <= `UEVC_ERR_RESET;
		end else begin
			enables <= next_enables;
		end
	end

	// unmasked error summary
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			summary <= 1'b0;
		end else begin
			summary <= |(next_flags & next_enables); // [R23]
		end
	end

endmodule

// file: rtl/uevc_pwm.sv
`timescale 1ns/1ns

module uevc_pwm #(
	parameter int WIDTH = 16
) (
	input  wire logic             clock,
	input  wire logic             resetn,
	input  wire logic             gen_enable,
	input  wire logic             polarity,
	input  wire logic             counter_enable,
	input  wire logic [WIDTH-1:0] period,
	input  wire logic [WIDTH-1:0] duty,
	output logic                  pwm_out
);

	logic [WIDTH-1:0] count;

	// free counter, runs only while both enables are set
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			count <= '0;
		end else if (!gen_enable) begin
			count <= '0;
		end else if (counter_enable) begin // [R21]
			count <= (count >= period) ? '0 : count + 1'b1;
		end
	end

	// output, idle level given by polarity while off
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			pwm_out <= 1'b0;
		end else if (!gen_enable) begin
			pwm_out <= polarity; // [R19] [R20]
		end else if (counter_enable) begin
			pwm_out <= (count < duty) ^ polarity; // [R25] [R20]
		end
	end

endmodule

// file: rtl/uevc_top.sv
// The plain strobed port and the register addresses were left to the implementer.
`timescale 1ns/1ns
`include "uevc_map.svh"

//Function
// R1: bit stuff error sets a sticky flag until software clears it.
// R2: bytes beyond descriptor count raise overrun flag and are not stored.
// R3: missing response within turnaround window sets timeout flag.
// R4: data field not whole bytes sets partial byte flag.
// R5: failed data CRC16 sets data checksum flag.
// R6: device mode: bit 1 flags token rejected by CRC5 failure.
// R7: host mode: bit 1 flags activity running past frame boundary.
// R8: failed PID complement check sets packet id flag.
// R9: writing one clears an error flag; software writes whole words.
// R10: error enable register has one enable per flag, same positions.
// R11: sixteen independent endpoint control registers, endpoints 0 to 15.
// R12: endpoint 0 low speed bit enables direct low speed connection.
// R13: endpoint 0 retry disable bit stops hardware NAK retry.
// R14: low speed and retry bits exist only in endpoint 0, host mode.
// R15: with tx and rx enabled, setup block bit forbids SETUP transfers.
// R16: OUT accepted only with receive enable, IN sent only with transmit.
// R17: each endpoint holds a stall status bit set on stall.
// R18: handshakes sent only while handshake enable bit is set.
// R19: generator disabled holds output at polarity idle level.
// R20: polarity set: active low, idle high; clear: active high, idle low.
// R21: PWM counter runs only while counter enable is set.
// R22: unimplemented bits read zero and ignore writes.
// R23: summary flag set only by an error flag whose enable is set.
// R24: error flags latch regardless of their enable bits.
// R25: output follows compare points only with generator and counter on.
module uevc_top #(
	parameter int TURNAROUND_CYCLES = 16,
	parameter int BYTE_COUNT_W      = 10,
	parameter int PWM_W             = 16
) (
	input  wire logic                    clock,
	input  wire logic                    resetn,
	input  wire logic [`UEVC_ADDR_W-1:0] reg_addr,
	input  wire logic [15:0]             reg_wdata,
	input  wire logic                    reg_write,
	input  wire logic                    reg_read,
	output logic      [15:0]             reg_rdata,
	input  wire logic                    host_mode,
	input  wire logic                    bit_stuff_event,
	input  wire logic                    partial_byte_event,
	input  wire logic                    data_checksum_event,
	input  wire logic                    token_checksum_event,
	input  wire logic                    packet_id_event,
	input  wire logic                    frame_boundary,
	input  wire logic                    bus_active,
	input  wire logic                    response_expected,
	input  wire logic                    response_start,
	input  wire logic                    rx_packet_start,
	input  wire logic                    rx_byte_valid,
	input  wire logic [7:0]              rx_byte,
	input  wire logic [BYTE_COUNT_W-1:0] bd_byte_count,
	output logic                         rx_store_valid,
	output logic      [7:0]              rx_store_byte,
	input  wire logic                    token_valid,
	input  wire logic [3:0]              token_ep,
	input  wire logic                    stall_event,
	input  wire logic [3:0]              stall_ep,
	output logic                         ep_out_accept,
	output logic                         ep_in_send,
	output logic                         ep_setup_accept,
	output logic                         ep_handshake_send,
	output logic                         low_speed_direct,
	output logic                         nak_retry_enable,
	input  wire logic [PWM_W-1:0]        pwm_period,
	input  wire logic [PWM_W-1:0]        pwm_duty,
	output logic                         vbus_pwm_out,
	output logic                         usb_error_summary_flag
);

	// ------------------------------------------------------------
	// declarations
	// ------------------------------------------------------------
	localparam int TA_W = $clog2(TURNAROUND_CYCLES + 1);
	localparam logic [TA_W-1:0] TA_LAST =
		TA_W'(TURNAROUND_CYCLES - 1);

	logic [7:0]              ep_regs [16];
	logic [7:0]              err_flags;
	logic [7:0]              err_enables;
	logic [7:0]              err_events;
	logic                    vbus_gen_enable;
	logic                    vbus_gen_polarity;
	logic                    vbus_counter_enable;
	logic                    ep_sel;
	logic [3:0]              ep_idx;
	logic                    wr_flags;
	logic                    wr_enables;
	logic                    overrun_event;
	logic                    timeout_event;
	logic                    frame_event;
	logic [BYTE_COUNT_W-1:0] rx_count;
	logic [TA_W-1:0]         ta_count;
	logic [7:0]              token_view;
	logic [7:0]              ep0_view;
	logic [15:0]             next_rdata;
	uevc_pkg::uevc_ta_state_t ta_state;

	// ------------------------------------------------------------
	// address decode
	// ------------------------------------------------------------

	// endpoint window and single-register strobes
	assign ep_sel     = (reg_addr[`UEVC_EP_SEL_HI:`UEVC_EP_SEL_LO] ==
	                     `UEVC_EP_SEL_VAL);
	assign ep_idx     = reg_addr[3:0];
	assign wr_flags   = reg_write && (reg_addr == `UEVC_REG_ERR_FLAGS);
	assign wr_enables = reg_write && (reg_addr == `UEVC_REG_ERR_ENABLES);

	// ------------------------------------------------------------
	// error events
	// ------------------------------------------------------------

	// frame overrun: bus still busy when the frame boundary arrives
	assign frame_event = host_mode && frame_boundary && bus_active; // [R7]

	// gather the event pulses into flag positions
	always_comb begin
		err_events = 8'h00;
		err_events[`UEVC_ERR_BIT_STUFF]   = bit_stuff_event; // [R1]
		err_events[`UEVC_ERR_OVERRUN]     = overrun_event; // [R2]
		err_events[`UEVC_ERR_TIMEOUT]     = timeout_event; // [R3]
		err_events[`UEVC_ERR_PARTIAL]     = partial_byte_event; // [R4]
		err_events[`UEVC_ERR_DATA_CRC]    = data_checksum_event; // [R5]
		err_events[`UEVC_ERR_TOKEN_FRAME] = host_mode ? frame_event :
		                 token_checksum_event; // [R6] [R7]
		err_events[`UEVC_ERR_PID]         = packet_id_event; // [R8]
	end

	// sticky flags, enables and summary
	uevc_err_flags u_err_flags (
		.clock       (clock),
		.resetn      (resetn),
		.event_vec   (err_events),
		.clear_wr    (wr_flags),
		.clear_data  (reg_wdata[7:0]),
		.enable_wr   (wr_enables),
		.enable_data (reg_wdata[7:0]),
		.flags       (err_flags),
		.enables     (err_enables),
		.summary     (usb_error_summary_flag)
	);

	// ------------------------------------------------------------
	// receive truncation against the descriptor byte count
	// ------------------------------------------------------------

	// bytes taken in the current packet
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			rx_count <= '0;
		end else if (rx_packet_start) begin
			rx_count <= '0;
		end else if (rx_byte_valid && rx_count < bd_byte_count) begin
			rx_count <= rx_count + 1'b1;
		end
	end

	// store stroke only while room remains, excess raises overrun
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			rx_store_valid <= 1'b0;
			rx_store_byte  <= 8'h00;
			overrun_event  <= 1'b0;
		end else begin
			rx_store_valid <= rx_byte_valid && !rx_packet_start &&
			                  (rx_count < bd_byte_count); // [R2]
			overrun_event  <= rx_byte_valid && !rx_packet_start &&
			                  (rx_count >= bd_byte_count); // [R2]
			if (rx_byte_valid) begin
				rx_store_byte <= rx_byte;
			end
		end
	end

	// ------------------------------------------------------------
	// bus turnaround watchdog
	// ------------------------------------------------------------

	// wait for the response to begin, flag it if the window runs out
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			ta_state      <= uevc_pkg::ta_idle;
			ta_count      <= '0;
			timeout_event <= 1'b0;
		end else begin
			timeout_event <= 1'b0;
			unique case (ta_state)
				uevc_pkg::ta_idle: begin
					ta_count <= '0;
					if (response_expected) begin
						ta_state <= uevc_pkg::ta_waiting;
					end
				end
				uevc_pkg::ta_waiting: begin
					if (response_start) begin
						ta_state <= uevc_pkg::ta_idle;
					end else if (ta_count == TA_LAST) begin
						timeout_event <= 1'b1; // [R3]
						ta_state      <= uevc_pkg::ta_idle;
					end else begin
						ta_count <= ta_count + 1'b1;
					end
				end
			endcase
		end
	end

	// ------------------------------------------------------------
	// endpoint control registers
	// ------------------------------------------------------------

	// one register per endpoint, stall from the engine beats a write
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			for (int i = 0; i < 16; i++) begin
				ep_regs[i] <= `UEVC_EP_RESET; // [R11]
			end
		end else begin
			for (int i = 0; i < 16; i++) begin
				if (reg_write && ep_sel && ep_idx == 4'(i)) begin
					ep_regs[i] <= reg_wdata[7:0] & ((i == 0) ?
					              `UEVC_EP0_HOST_MASK :
					              `UEVC_EP_MASK); // [R14] [R22]
				end
				if (stall_event && stall_ep == 4'(i)) begin
					ep_regs[i][`UEVC_EP_STALLED] <= 1'b1; // [R17]
				end
			end
		end
	end

	// views of the addressed endpoint and of endpoint zero
	assign token_view = uevc_pkg::uevc_ep_view(token_ep, host_mode,
	                                            ep_regs[token_ep]);
	assign ep0_view   = uevc_pkg::uevc_ep_view(4'h0, host_mode,
	                                            ep_regs[0]);

	// per-token permissions, held until the next token
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			ep_out_accept     <= 1'b0;
			ep_in_send        <= 1'b0;
			ep_setup_accept   <= 1'b0;
			ep_handshake_send <= 1'b0;
		end else if (token_valid) begin
			ep_out_accept     <= token_view[`UEVC_EP_RX_EN]; // [R16]
			ep_in_send        <= token_view[`UEVC_EP_TX_EN]; // [R16]
			ep_setup_accept   <= token_view[`UEVC_EP_RX_EN] &&
			                     token_view[`UEVC_EP_TX_EN] &&
			                     !token_view[`UEVC_EP_SETUP_BLOCK]; // [R15]
			ep_handshake_send <= token_view[`UEVC_EP_HSHK_EN]; // [R18]
		end
	end

	// endpoint zero host controls
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			low_speed_direct <= 1'b0;
			nak_retry_enable <= 1'b0;
		end else begin
			low_speed_direct <= ep0_view[`UEVC_EP_LOW_SPEED]; // [R12]
			nak_retry_enable <= host_mode &&
			                    !ep0_view[`UEVC_EP_RETRY_DIS]; // [R13]
		end
	end

	// ------------------------------------------------------------
	// vbus generator control
	// ------------------------------------------------------------

	// control bits, only the implemented three are stored
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			vbus_gen_enable     <= `UEVC_PWM_RESET;
			vbus_gen_polarity   <= `UEVC_PWM_RESET;
			vbus_counter_enable <= `UEVC_PWM_RESET;
		end else if (reg_write && reg_addr == `UEVC_REG_PWM_CTRL) begin
			vbus_gen_enable     <= reg_wdata[`UEVC_PWM_GEN_EN]; // [R22]
			vbus_gen_polarity   <= reg_wdata[`UEVC_PWM_POL];
			vbus_counter_enable <= reg_wdata[`UEVC_PWM_CNT_EN];
		end
	end

	// the generator itself
	uevc_pwm #(
		.WIDTH (PWM_W)
	) u_pwm (
		.clock          (clock),
		.resetn         (resetn),
		.gen_enable     (vbus_gen_enable), // [R19]
		.polarity       (vbus_gen_polarity),
		.counter_enable (vbus_counter_enable), // [R21]
		.period         (pwm_period),
		.duty           (pwm_duty),
		.pwm_out        (vbus_pwm_out)
	);

	// ------------------------------------------------------------
	// read path
	// ------------------------------------------------------------

	// select the addressed register, unmapped reads give zero
	always_comb begin
		next_rdata = 16'h0000;
		if (reg_read) begin
			if (ep_sel) begin
				next_rdata[7:0] = uevc_pkg::uevc_ep_view(ep_idx,
				                  host_mode, ep_regs[ep_idx]); // [R14]
			end else if (reg_addr == `UEVC_REG_ERR_FLAGS) begin
				next_rdata[7:0] = err_flags; // [R22]
			end else if (reg_addr == `UEVC_REG_ERR_ENABLES) begin
				next_rdata[7:0] = err_enables; // [R10]
			end else if (reg_addr == `UEVC_REG_PWM_CTRL) begin
				next_rdata[`UEVC_PWM_GEN_EN] = vbus_gen_enable;
				next_rdata[`UEVC_PWM_POL]    = vbus_gen_polarity;
				next_rdata[`UEVC_PWM_CNT_EN] = vbus_counter_enable;
			end
		end
	end

	// read data stands in the cycle after the strobe only
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			reg_rdata <= 16'h0000;
		end else begin
			reg_rdata <= next_rdata;
		end
	end

endmodule

// file: verif/uevc_monitor.sv
`timescale 1ns/1ns

// port checks
module uevc_monitor (
	input wire logic        clock,
	input wire logic        resetn,
	input wire logic [5:0]  reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic        reg_write,
	input wire logic        reg_read,
	input wire logic [15:0] reg_rdata,
	input wire logic        host_mode,
	input wire logic        bit_stuff_event,
	input wire logic        rx_byte_valid,
	input wire logic [7:0]  rx_byte,
	input wire logic        rx_store_valid,
	input wire logic [7:0]  rx_store_byte,
	input wire logic        token_valid,
	input wire logic        ep_out_accept,
	input wire logic        ep_in_send,
	input wire logic        ep_setup_accept,
	input wire logic        ep_handshake_send,
	input wire logic        usb_error_summary_flag
);
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!resetn);

	// ----------------------------------------
	// register port, flags and receive store
	// ----------------------------------------
	property p_unmapped;
		reg_read && reg_addr > 6'h02 && reg_addr[5:4] != 2'h1 |=> reg_rdata == 16'h0;
	endproperty
	a_unmapped: assert property (p_unmapped)
		else $error("unmapped read not zero");
	property p_pwm_read;
		reg_read && reg_addr == 6'h02 |=> (reg_rdata & 16'h7cff) == 16'h0;
	endproperty
	a_pwm_read: assert property (p_pwm_read)
		else $error("pwm spare bits set");
	property p_ep_read;
		reg_read && reg_addr[5:4] == 2'h1 && (reg_addr[3:0] != 4'h0 || !host_mode)
			|=> reg_rdata[15:5] == 11'h0;
	endproperty
	a_ep_read: assert property (p_ep_read)
		else $error("ep spare bits set");
	property p_stuff_seen;
		bit_stuff_event ##1 !reg_write ##1 reg_read && reg_addr == 6'h00
			|=> reg_rdata[7];
	endproperty
	a_stuff_seen: assert property (p_stuff_seen)
		else $error("stuff flag lost");
	property p_summary_mask;
		reg_write && reg_addr == 6'h01 && reg_wdata[7:0] == 8'h00
			|=> !usb_error_summary_flag;
	endproperty
	a_summary_mask: assert property (p_summary_mask)
		else $error("summary not masked");
	property p_rx_store;
		rx_store_valid |-> $past(rx_byte_valid) && rx_store_byte == $past(rx_byte);
	endproperty
	a_rx_store: assert property (p_rx_store)
		else $error("stored byte wrong");

	// ----------------------------------------
	// endpoint query outputs
	// ----------------------------------------
	property p_setup;
		ep_setup_accept |-> ep_out_accept && ep_in_send;
	endproperty
	a_setup: assert property (p_setup)
		else $error("setup without rx tx");
	property p_hold;
		!token_valid |=> $stable({ep_out_accept, ep_in_send,
			ep_setup_accept, ep_handshake_send});
	endproperty
	a_hold: assert property (p_hold)
		else $error("permissions moved");
endmodule

bind uevc_top uevc_monitor mon_u (.*);

// file: verif/uevc_engine_model.sv
`timescale 1ns/1ns

// usb engine stand-in
module uevc_engine_model (
	input  wire logic  clock,
	output logic       bit_stuff_event,
	output logic       partial_byte_event,
	output logic       data_checksum_event,
	output logic       token_checksum_event,
	output logic       packet_id_event,
	output logic       frame_boundary,
	output logic       bus_active,
	output logic       response_expected,
	output logic       response_start,
	output logic       rx_packet_start,
	output logic       rx_byte_valid,
	output logic [7:0] rx_byte,
	output logic [9:0] bd_byte_count,
	output logic       token_valid,
	output logic [3:0] token_ep,
	output logic       stall_event,
	output logic [3:0] stall_ep
);
	logic [5:0] evs;

	// one-hot pulses; bus activity flips at each frame boundary
	assign {frame_boundary, packet_id_event, token_checksum_event,
	        data_checksum_event, partial_byte_event, bit_stuff_event} = evs;
	always @(posedge clock) if (frame_boundary) bus_active <= !bus_active;

	// quiet engine from time zero
	initial begin
		{evs, response_expected, response_start, rx_packet_start} = '0;
		{rx_byte_valid, rx_byte, bd_byte_count, token_valid} = '0;
		{token_ep, stall_event, stall_ep, bus_active} = '0;
	end

	// one detector pulse
	task automatic ev(input int i);
		@(posedge clock);
		evs <= 6'h01 << i;
		@(posedge clock);
		evs <= 6'h00;
	endtask

	// n bytes, cnt allowed
	task automatic rx(input int cnt, input int n);
		@(posedge clock);
		bd_byte_count <= 10'(cnt);
		rx_packet_start <= 1'b1;
		@(posedge clock);
		rx_packet_start <= 1'b0;
		for (int k = 0; k < n; k++) begin
			rx_byte_valid <= 1'b1;
			rx_byte <= 8'(8'ha5 + k);
			@(posedge clock);
		end
		rx_byte_valid <= 1'b0;
		rx_byte <= ~rx_byte;
	endtask

	// response after gap cycles, none for 0
	task automatic ta(input int gap);
		@(posedge clock);
		response_expected <= 1'b1;
		@(posedge clock);
		response_expected <= 1'b0;
		if (gap > 0) begin
			repeat (gap - 1) @(posedge clock);
			response_start <= 1'b1;
			@(posedge clock);
			response_start <= 1'b0;
		end
	endtask

	// token query or stall report
	task automatic tok(input logic [3:0] ep, input logic st);
		@(posedge clock);
		token_valid <= !st;
		stall_event <= st;
		token_ep <= ep;
		stall_ep <= ep;
		@(posedge clock);
		{token_valid, stall_event} <= 2'h0;
		token_ep <= ~ep;
		stall_ep <= ~ep;
	endtask
endmodule

// file: verif/tb_top.sv
`timescale 1ns/1ns

module tb_top;
	logic        clock = 1'b0;
	logic        resetn = 1'b0;
	logic [5:0]  reg_addr;
	logic [15:0] reg_wdata;
	logic        reg_write = 1'b0;
	logic        reg_read = 1'b0;
	logic        host_mode = 1'b0;
	logic [15:0] pwm_period;
	logic [15:0] pwm_duty;
	logic [15:0] reg_rdata;
	logic [7:0]  rx_byte, rx_store_byte;
	logic [9:0]  bd_byte_count;
	logic [3:0]  token_ep, stall_ep;
	logic        bit_stuff_event, partial_byte_event, data_checksum_event;
	logic        token_checksum_event, packet_id_event, frame_boundary;
	logic        bus_active, response_expected, response_start;
	logic        rx_packet_start, rx_byte_valid, rx_store_valid;
	logic        token_valid, stall_event, ep_out_accept, ep_in_send;
	logic        ep_setup_accept, ep_handshake_send, low_speed_direct;
	logic        nak_retry_enable, vbus_pwm_out, usb_error_summary_flag;
	int          errors;
	int          n_tests;
	int          stores;

	// ----------------------------------------
	// design, engine and clock
	// ----------------------------------------
	uevc_top #(.TURNAROUND_CYCLES(4)) dut_u (.*);
	uevc_engine_model eng_u (.*);
	always #5 clock = ~clock;
	// stored bytes
	always @(posedge clock) if (rx_store_valid === 1'b1) stores++;

	// ----------------------------------------
	// bus and compare tasks
	// ----------------------------------------
	task automatic chk(input string nm, input logic [15:0] e,
	                   input logic [15:0] g);
		n_tests++;
		if (g !== e) begin
			errors++;
			$display("unexpected %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic wr(input logic [5:0] a, input logic [15:0] d);
		@(posedge clock);
		{reg_write, reg_addr, reg_wdata} <= {1'b1, a, d};
		@(posedge clock);
		reg_write <= 1'b0;
		#1;
	endtask
	task automatic rd(input logic [5:0] a, input logic [15:0] e);
		@(posedge clock);
		{reg_read, reg_addr} <= {1'b1, a};
		@(posedge clock);
		reg_read <= 1'b0;
		#1 chk($sformatf("reg %h", a), e, reg_rdata);
	endtask
	// highs in 40 cycles; -1 means frozen
	task automatic pwm_count(input int e);
		int h = 0;
		repeat (4) @(posedge clock);
		repeat (40) @(posedge clock) h += (vbus_pwm_out === 1'b1);
		if (e < 0) e = (h == 0) ? 0 : 40;
		chk("pwm highs", 16'(e), 16'(h));
	endtask
	task automatic end_sim();
		$display("checks %0d mismatches %0d", n_tests, errors);
		if (errors == 0 && n_tests > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_regs();
		wr(6'h03, 16'hffff);
		rd(6'h03, 16'h0000);
		for (int a = 0; a < 19; a++)
			rd(a < 3 ? 6'(a) : 6'(a + 13), 16'h0000);
		$display("regs test done");
	endtask
	task automatic t_err();
		int pos[5] = '{7, 3, 2, 1, 0};
		logic [15:0] b;
		wr(6'h01, 16'hffff);
		rd(6'h01, 16'h00bf);
		for (int i = 0; i < 5; i++) begin
			b = 16'h0001 << pos[i];
			eng_u.ev(i);
			rd(6'h00, b);
			chk("summary", 16'h1, 16'(usb_error_summary_flag));
			wr(6'h00, b);
		end
		eng_u.ev(0);
		eng_u.ev(4);
		wr(6'h00, 16'h0001);
		rd(6'h00, 16'h0080);
		wr(6'h01, 16'h0000);
		chk("summary", 16'h0, 16'(usb_error_summary_flag));
		eng_u.ev(4);
		rd(6'h00, 16'h0081);
		wr(6'h01, 16'h0001);
		chk("summary", 16'h1, 16'(usb_error_summary_flag));
		wr(6'h00, 16'hffff);
		rd(6'h00, 16'h0000);
		host_mode <= 1'b1;
		eng_u.ev(3);
		rd(6'h00, 16'h0000);
		eng_u.ev(5);
		rd(6'h00, 16'h0000);
		eng_u.ev(5);
		rd(6'h00, 16'h0002);
		wr(6'h00, 16'h0002);
		host_mode <= 1'b0;
		$display("error test done");
	endtask
	task automatic t_rx_ta();
		stores = 0;
		eng_u.rx(3, 5);
		repeat (4) @(posedge clock);
		chk("stores", 16'h0003, 16'(stores));
		rd(6'h00, 16'h0020);
		wr(6'h00, 16'h0020);
		stores = 0;
		eng_u.rx(4, 4);
		repeat (4) @(posedge clock);
		chk("stores", 16'h0004, 16'(stores));
		eng_u.ta(4);
		repeat (8) @(posedge clock);
		rd(6'h00, 16'h0000);
		eng_u.ta(5);
		repeat (8) @(posedge clock);
		rd(6'h00, 16'h0010);
		$display("rx test done");
	endtask
	task automatic t_ep();
		logic [4:0] v;
		host_mode <= 1'b1;
		for (int n = 0; n < 16; n++)
			wr(6'(16 + n), 16'hffe0 | 16'(n));
		for (int n = 0; n < 16; n++)
			rd(6'(16 + n), n == 0 ? 16'h00c0 : 16'(n));
		chk("low speed", 16'h1, 16'(low_speed_direct));
		chk("nak retry", 16'h0, 16'(nak_retry_enable));
		wr(6'h10, 16'h0000);
		rd(6'h10, 16'h0000);
		chk("low speed", 16'h0, 16'(low_speed_direct));
		chk("nak retry", 16'h1, 16'(nak_retry_enable));
		host_mode <= 1'b0;
		wr(6'h10, 16'h00c0);
		rd(6'h10, 16'h0000);
		chk("nak retry", 16'h0, 16'(nak_retry_enable));
		for (int k = 0; k < 32; k++) begin
			v = 5'(k);
			wr(6'h15, {11'h0, v});
			eng_u.tok(4'h5, 1'b0);
			#1 chk("perm", {12'h0, v[3] & v[2] & !v[4], v[3], v[2], v[0]},
			    {12'h0, ep_setup_accept, ep_out_accept, ep_in_send,
			     ep_handshake_send});
		end
		wr(6'h19, 16'h0000);
		eng_u.tok(4'h9, 1'b1);
		rd(6'h19, 16'h0002);
		$display("ep test done");
	endtask
	task automatic t_pwm();
		pwm_period <= 16'h0003;
		pwm_duty <= 16'h0001;
		wr(6'h02, 16'hffff);
		rd(6'h02, 16'h8300);
		wr(6'h02, 16'h0200);
		pwm_count(40);
		wr(6'h02, 16'h0000);
		pwm_count(0);
		wr(6'h02, 16'h8100);
		pwm_count(10);
		wr(6'h02, 16'h8300);
		pwm_count(30);
		wr(6'h02, 16'h8200);
		pwm_count(-1);
		$display("pwm test done");
	endtask

	// main sequence and watchdog
	initial begin
		repeat (8) @(posedge clock);
		resetn <= 1'b1;
		t_regs();
		t_err();
		t_rx_ta();
		t_ep();
		t_pwm();
		end_sim();
	end
	initial begin
		#200000;
		errors++;
		end_sim();
	end
endmodule
